/* logic/mpis_top.sv */
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mpis_regs.svh"

// Functional notes
// R01 - Ack address is base plus cpu shifted twelve
// R02 - Ack read returns requesting source vector
// R03 - Acknowledged level blocks equal or lower priority
// R04 - End of interrupt retires highest in-service
// R05 - Software writes zero as end of interrupt
// R06 - Private end of interrupt and task priority
// R07 - Task priority resets to fifteen
// R08 - Sources reset masked, priority zero, inactive
// R09 - Init cleared, timer stopped, interrupt masked
// R10 - Reset in pass-through: source zero to cpu0
// R11 - Software selects mixed mode at init
// R12 - Four interprocessor channels with vector/priority
// R13 - Dispatch mask raises interrupt, shared, two addresses
// R14 - Own bit in mask gives self-interrupt
// R15 - Mask, wait inactive, change, unmask
// R16 - Deliver only above current task priority
// R17 - Task priorities choose distributed destination
// R18 - Task priority change may act late
// R19 - Level source negated scan length before end
// R20 - Serial scan delays level changes seen
// R21 - Legacy second vector fetch not served here
// R22 - End of interrupt clears legacy in-service bit
// R23 - Ack sets, end of interrupt clears in-service
// R24 - Edge pending clears on ack, level follows
// R25 - Masked condition remembered until unmasked
// R26 - Task priority four bits, fifteen blocks all
module mpis_top
  import mpis_pkg::*;
#(
  parameter int SCAN_DIV = `MPIS_SCAN_DIV
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [23:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [15:0] ext_irq,
  output var  logic [1:0]  cpu_int,
  output var  logic [1:0]  cpu_init
);

  localparam int NS = `MPIS_NSRC;
  localparam logic [23:0] ACK_A   = `MPIS_ACK_OFS;
  localparam logic [23:0] CTP_A   = `MPIS_CTP_OFS;
  localparam logic [23:0] EOI_A   = `MPIS_EOI_OFS;
  localparam logic [23:0] DISP_A  = `MPIS_DISP_OFS;
  localparam logic [23:0] IPIVP_A = `MPIS_IPIVP_OFS;
  localparam logic [23:0] EXTVP_A = `MPIS_EXTVP_OFS;

  if (SCAN_DIV < 1 || SCAN_DIV > 256)
  begin : g_bad_div
    $error("SCAN_DIV out of range");
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  mpis_vp_t          vp [NS];
  logic [1:0]        ext_dst [16];
  logic [3:0]        ctp [2];
  logic              mixed;
  logic              tie_cpu1;
  logic              tinh;
  logic [30:0]       tbase;
  logic [30:0]       tcnt;
  logic [NS-1:0]     in_service_record [2];
  mpis_sel_t         irr [2];
  logic [15:0]       ext_pend;
  logic              tim_pend;
  logic [3:0]        ipi_pend [2];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  mpis_reg_t  reg_sel;
  logic       reg_cpu;
  logic [3:0] reg_idx;
  logic       setup;
  logic       fire;
  logic       wr_fire;

  assign setup   = psel && !penable;
  assign fire    = psel && penable && pready;
  assign wr_fire = fire && pwrite;
  assign reg_cpu = paddr[12];

  always_comb
  begin
    reg_sel = MPIS_R_NONE;
    reg_idx = 4'h0;
    if (paddr[23:13] == ACK_A[23:13])
    begin
      if (paddr[11:0] == ACK_A[11:0])
        reg_sel = MPIS_R_ACK; // R01
      else if (paddr[11:0] == CTP_A[11:0])
        reg_sel = MPIS_R_CTP;
      else if (paddr[11:0] == EOI_A[11:0])
        reg_sel = MPIS_R_EOI;
      else if (paddr[11:6] == DISP_A[11:6] && paddr[3:0] == 4'h0)
      begin
        reg_sel = MPIS_R_DISP;
        reg_idx = {2'h0, paddr[5:4]};
      end
    end
    else if (paddr == `MPIS_GCFG_OFS)
      reg_sel = MPIS_R_GCFG;
    else if (paddr == `MPIS_PINIT_OFS)
      reg_sel = MPIS_R_PINIT;
    else if (paddr == `MPIS_TBASE_OFS)
      reg_sel = MPIS_R_TBASE;
    else if (paddr == `MPIS_TVP_OFS)
      reg_sel = MPIS_R_TVP;
    else if (paddr[23:6] == IPIVP_A[23:6] && paddr[3:0] == 4'h0)
    begin
      reg_sel = MPIS_R_IPIVP;
      reg_idx = {2'h0, paddr[5:4]};
    end
    else if (paddr[23:9] == EXTVP_A[23:9] && paddr[3:0] == 4'h0)
    begin
      reg_sel = paddr[4] ? MPIS_R_EXTDST : MPIS_R_EXTVP;
      reg_idx = paddr[8:5];
    end
  end

  // ****************************************************************
  // External inputs: synchroniser and serial scan
  // ****************************************************************
  logic [15:0] ext_s1, ext_s2, ext_s3, ext_stable, scanned, ext_prev;
  logic [15:0] ext_act;
  logic [7:0]  div_cnt;
  logic        scan_tick;
  logic [3:0]  scan_idx;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1     <= 16'h0;
      ext_s2     <= 16'h0;
      ext_s3     <= 16'h0;
      ext_stable <= 16'h0;
    end
    else
    begin
      ext_s1     <= ext_irq;
      ext_s2     <= ext_s1;
      ext_s3     <= ext_s2;
      ext_stable <= (~(ext_s2 ^ ext_s3) & ext_s3) | ((ext_s2 ^ ext_s3) & ext_stable);
    end
  end

  // One input per tick: a level change is seen up to a full scan late
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt   <= 8'h0;
      scan_tick <= 1'b0;
      scan_idx  <= 4'h0;
      scanned   <= 16'h0;
    end
    else
    begin
      scan_tick <= (div_cnt == 8'(SCAN_DIV - 1));
      div_cnt   <= (div_cnt == 8'(SCAN_DIV - 1)) ? 8'h0 : div_cnt + 8'h1;
      if (scan_tick)
      begin
        scanned[scan_idx] <= ext_stable[scan_idx]; // R20
        scan_idx          <= scan_idx + 4'h1;
      end
    end
  end

  always_comb
  begin
    for (int s = 0; s < 16; s++)
      ext_act[s] = (scanned[s] == vp[s].pol);
  end

  // ****************************************************************
  // Selection and routing
  // ****************************************************************
  function automatic mpis_sel_t pick(input logic [NS-1:0] req, input logic [NS-1:0][3:0] pr);
    mpis_sel_t r;
    r = '0;
    for (int s = 0; s < NS; s++)
      if (req[s] && (!r.valid || pr[s] > r.prio))
      begin
        r.valid = 1'b1;
        r.src   = 5'(s);
        r.prio  = pr[s];
      end
    return r;
  endfunction

  logic [NS-1:0][3:0] prio_of;
  logic [NS-1:0]      req [2];
  mpis_sel_t          sel [2];
  mpis_sel_t          isr_top [2];
  logic [1:0]         deliver;
  logic [1:0]         freeze;
  logic [NS-1:0]      act;

  always_comb
  begin
    for (int s = 0; s < NS; s++)
      prio_of[s] = vp[s].prio;
    for (int c = 0; c < 2; c++)
    begin
      for (int s = 0; s < 16; s++)
        req[c][s] = ext_pend[s] && !vp[s].mask && ext_dst[s][c]; // R25
      req[c][16] = (c == 0) && tim_pend && !vp[16].mask;
      for (int k = 0; k < 4; k++)
        req[c][17 + k] = ipi_pend[c][k] && !vp[17 + k].mask;
      req[c]     = req[c] & ~in_service_record[c];
      sel[c]     = pick(req[c], prio_of);
      isr_top[c] = pick(in_service_record[c], prio_of);
      deliver[c] = irr[c].valid && (irr[c].prio > ctp[c]) // R16 R26
        && (!isr_top[c].valid || irr[c].prio > isr_top[c].prio); // R03
      if (irr[c].valid && irr[c].src < `MPIS_SRC_TIMER && ext_dst[irr[c].src[3:0]] == 2'h3)
        deliver[c] = deliver[c] && !in_service_record[1 - c][irr[c].src]
          && ((ctp[c] < ctp[1 - c]) || (ctp[c] == ctp[1 - c] && tie_cpu1 == c[0])); // R17
      freeze[c] = psel && reg_sel == MPIS_R_ACK && reg_cpu == c[0];
    end
    for (int s = 0; s < NS; s++)
      act[s] = in_service_record[0][s] || in_service_record[1][s];
    for (int s = 0; s < 16; s++)
      act[s] = act[s] || ext_pend[s];
    act[16] = act[16] || tim_pend;
    for (int k = 0; k < 4; k++)
      act[17 + k] = act[17 + k] || ipi_pend[0][k] || ipi_pend[1][k];
  end

  // Request register held during an acknowledge so the vector cannot move
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irr[0] <= '0;
      irr[1] <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
        if (!freeze[c])
          irr[c] <= sel[c];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_int <= 2'h0;
    else if (!mixed)
      cpu_int <= {1'b0, ext_stable[0]}; // R10
    else
      cpu_int <= deliver;
  end

  // ****************************************************************
  // Acknowledge and in-service record
  // ****************************************************************
  logic      ack_ok;
  logic      ack_cpu;
  mpis_src_t ack_src;
  logic      ack_fire;
  logic [1:0] eoi_fire;

  assign ack_fire = fire && ack_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_ok  <= 1'b0;
      ack_cpu <= 1'b0;
      ack_src <= '0;
    end
    else if (setup && !pwrite && reg_sel == MPIS_R_ACK)
    begin
      ack_ok  <= mixed && deliver[reg_cpu];
      ack_cpu <= reg_cpu;
      ack_src <= irr[reg_cpu].src;
    end
    else if (fire)
      ack_ok <= 1'b0;
  end

  always_comb
  begin
    for (int c = 0; c < 2; c++)
      eoi_fire[c] = wr_fire && reg_sel == MPIS_R_EOI && reg_cpu == c[0]; // R06
  end

  // Write data of an end of interrupt is ignored: only the nonspecific form exists
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_service_record[0] <= '0;
      in_service_record[1] <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (eoi_fire[c] && isr_top[c].valid)
          in_service_record[c][isr_top[c].src] <= 1'b0; // R04 R22
        if (ack_fire && ack_cpu == c[0])
          in_service_record[c][ack_src] <= 1'b1; // R23
      end
    end
  end

  // ****************************************************************
  // Pending capture
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Reset polarity makes every source look active: no false edge after reset
      ext_prev <= 16'hffff;
      ext_pend <= 16'h0;
    end
    else
    begin
      ext_prev <= ext_act;
      for (int s = 0; s < 16; s++)
        if (vp[s].sense)
          ext_pend[s] <= ext_act[s]; // R24
        else if (ext_act[s] && !ext_prev[s])
          ext_pend[s] <= 1'b1;
        else if (ack_fire && ack_src == 5'(s))
          ext_pend[s] <= 1'b0; // R24
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ipi_pend[0] <= 4'h0;
      ipi_pend[1] <= 4'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
        for (int k = 0; k < 4; k++)
          if (wr_fire && reg_sel == MPIS_R_DISP && reg_idx[1:0] == 2'(k) && pwdata[c])
            ipi_pend[c][k] <= 1'b1; // R13 R14
          else if (ack_fire && ack_cpu == c[0] && ack_src == `MPIS_SRC_IPI0 + 5'(k))
            ipi_pend[c][k] <= 1'b0;
    end
  end

  // Timer counts only when released; it always targets cpu0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcnt     <= 31'h0;
      tim_pend <= 1'b0;
    end
    else
    begin
      if (wr_fire && reg_sel == MPIS_R_TBASE)
        tcnt <= pwdata[30:0];
      else if (!tinh)
        tcnt <= (tcnt == 31'h0) ? tbase : tcnt - 31'h1;
      if (!tinh && tcnt == 31'h0)
        tim_pend <= 1'b1;
      else if (ack_fire && ack_cpu == 1'b0 && ack_src == `MPIS_SRC_TIMER)
        tim_pend <= 1'b0;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int s = 0; s < NS; s++)
        vp[s] <= '{mask: 1'b1, default: '0}; // R08 R09
      for (int s = 0; s < 16; s++)
        ext_dst[s] <= `MPIS_DST_RST;
      ctp[0]   <= `MPIS_CTP_RST; // R07
      ctp[1]   <= `MPIS_CTP_RST;
      mixed    <= 1'b0; // R10
      tie_cpu1 <= 1'b0;
      tinh     <= 1'b1; // R09
      tbase    <= 31'h0;
      cpu_init <= 2'h0; // R09
    end
    else if (wr_fire)
    begin
      unique case (reg_sel)
        MPIS_R_CTP:    ctp[reg_cpu] <= pwdata[3:0]; // R06 R18
        MPIS_R_GCFG:
        begin
          mixed    <= pwdata[`MPIS_GCFG_MIXED];
          tie_cpu1 <= pwdata[`MPIS_GCFG_TIE];
        end
        MPIS_R_PINIT:  cpu_init <= pwdata[1:0];
        MPIS_R_TBASE:
        begin
          tinh  <= pwdata[`MPIS_TB_INHIBIT];
          tbase <= pwdata[30:0];
        end
        MPIS_R_TVP:    vp[16] <= {pwdata[31], 2'h0, pwdata[19:16], pwdata[7:0]};
        MPIS_R_IPIVP:  vp[17 + reg_idx[1:0]] <= {pwdata[31], 2'h0, pwdata[19:16], pwdata[7:0]}; // R12
        MPIS_R_EXTVP:  vp[reg_idx] <= {pwdata[31], pwdata[23:22], pwdata[19:16], pwdata[7:0]};
        MPIS_R_EXTDST: ext_dst[reg_idx] <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Read data and bus answer
  // ****************************************************************
  logic [31:0] rdval;
  logic [4:0]  vsrc;

  always_comb
  begin
    vsrc = 5'(reg_idx);
    if (reg_sel == MPIS_R_TVP)
      vsrc = `MPIS_SRC_TIMER;
    else if (reg_sel == MPIS_R_IPIVP)
      vsrc = `MPIS_SRC_IPI0 + {3'h0, reg_idx[1:0]};
    rdval = 32'h0;
    unique case (reg_sel)
      MPIS_R_ACK:
        rdval = {24'h0, (mixed && deliver[reg_cpu]) ? vp[irr[reg_cpu].src].vector
                                                    : `MPIS_SPUR_VEC}; // R02 R21
      MPIS_R_CTP:    rdval = {28'h0, ctp[reg_cpu]};
      MPIS_R_GCFG:   rdval = {30'h0, tie_cpu1, mixed};
      MPIS_R_PINIT:  rdval = {30'h0, cpu_init};
      MPIS_R_TBASE:  rdval = {tinh, tbase};
      MPIS_R_TVP, MPIS_R_IPIVP, MPIS_R_EXTVP:
        rdval = {vp[vsrc].mask, act[vsrc], 6'h0, vp[vsrc].pol, vp[vsrc].sense, 2'h0,
                 vp[vsrc].prio, 8'h0, vp[vsrc].vector}; // R15
      MPIS_R_EXTDST: rdval = {30'h0, ext_dst[reg_idx]};
      default:       rdval = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && reg_sel == MPIS_R_NONE;
      if (setup)
        prdata <= pwrite ? 32'h0 : rdval;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ack_vector: assert property (ack_fire |-> prdata[7:0] == vp[ack_src].vector) // R02
    else $error("ack vector mismatch");
  a_ack_sets_isr: assert property (ack_fire && !ack_cpu |=> in_service_record[0][$past(ack_src)]) // R23
    else $error("ack did not set in-service");
  a_eoi_retire: assert property (eoi_fire[0] && isr_top[0].valid && !(ack_fire && !ack_cpu)
    |=> !in_service_record[0][$past(isr_top[0].src)]) // R04
    else $error("eoi did not retire top");
  a_ctp_gate: assert property ($past(mixed) && cpu_int[0] // R16
    |-> $past(irr[0].valid && irr[0].prio > ctp[0]))
    else $error("delivered at or below task priority");
  a_nest_block: assert property ($past(mixed) && cpu_int[1] && $past(isr_top[1].valid) // R03
    |-> $past(irr[1].prio > isr_top[1].prio))
    else $error("nested block violated");
  a_pass_route: assert property (!mixed |=> cpu_int == {1'b0, $past(ext_stable[0])}) // R10
    else $error("pass-through routing wrong");
  a_ipi_self: assert property (wr_fire && reg_sel == MPIS_R_DISP && pwdata[1]
    |=> ipi_pend[1][$past(reg_idx[1:0])]) // R14
    else $error("dispatch not raised");
  a_mask_hold: assert property (ext_pend[1] && !vp[1].sense && vp[1].mask |=> ext_pend[1]) // R25
    else $error("masked pending lost");
  a_scan_slow: assert property (!scan_tick |=> $stable(scanned)) // R20
    else $error("scan changed off tick");
  a_ctp_block: assert property (ctp[0] == 4'hf && ctp[1] == 4'hf |-> deliver == 2'h0) // R26
    else $error("delivery at task priority fifteen");

  c_ack_done: cover property (ack_fire ##[1:20] eoi_fire[ack_cpu]);
  c_nested: cover property (isr_top[0].valid && deliver[0]);
  c_ipi_both: cover property (ipi_pend[0][0] && ipi_pend[1][0]);

endmodule // mpis_top

`default_nettype wire

/* logic/mpis_regs.svh */
`ifndef MPIS_REGS_SVH
`define MPIS_REGS_SVH

// ****************************************************************
// Counts
// ****************************************************************
`define MPIS_NEXT        16
`define MPIS_NIPI        4
`define MPIS_NSRC        21
`define MPIS_SRC_TIMER   5'd16
`define MPIS_SRC_IPI0    5'd17
`define MPIS_SCAN_LEN    16
`define MPIS_SCAN_DIV    1

// ****************************************************************
// Offsets (byte addresses on APB)
// ****************************************************************
`define MPIS_ACK_OFS     24'h200a00
`define MPIS_CTP_OFS     24'h200a80
`define MPIS_EOI_OFS     24'h200b00
`define MPIS_DISP_OFS    24'h200040
`define MPIS_GCFG_OFS    24'h001020
`define MPIS_PINIT_OFS   24'h001090
`define MPIS_IPIVP_OFS   24'h0010c0
`define MPIS_TBASE_OFS   24'h001110
`define MPIS_TVP_OFS     24'h001120
`define MPIS_EXTVP_OFS   24'h010000

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define MPIS_VP_MASK     31
`define MPIS_VP_ACT      30
`define MPIS_VP_POL      23
`define MPIS_VP_SENSE    22
`define MPIS_VP_PRIO     16
`define MPIS_GCFG_MIXED  0
`define MPIS_GCFG_TIE    1
`define MPIS_TB_INHIBIT  31
`define MPIS_CTP_RST     4'hf
`define MPIS_DST_RST     2'h1
`define MPIS_SPUR_VEC    8'hff

`endif

/* logic/mpis_pkg.sv */
package mpis_pkg;
  `include "mpis_regs.svh"

  typedef logic [4:0] mpis_src_t;

  typedef struct packed {
    logic       valid;
    mpis_src_t  src;
    logic [3:0] prio;
  } mpis_sel_t;

  typedef struct packed {
    logic       mask;
    logic       pol;
    logic       sense;
    logic [3:0] prio;
    logic [7:0] vector;
  } mpis_vp_t;

  typedef enum logic [3:0] {
    MPIS_R_NONE, MPIS_R_ACK, MPIS_R_CTP, MPIS_R_EOI, MPIS_R_DISP, MPIS_R_GCFG,
    MPIS_R_PINIT, MPIS_R_IPIVP, MPIS_R_TBASE, MPIS_R_TVP, MPIS_R_EXTVP, MPIS_R_EXTDST
  } mpis_reg_t;
endpackage

/* dv/mpis_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mpis_regs.svh"

module mpis_host_model
  import mpis_pkg::*;
(
  input  wire logic        pclk,
  output var  logic [23:0] paddr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        rerr;

  initial
  begin
    paddr = 24'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle edge first, so a release and a new setup never share a step
  task automatic xfer(input logic w, input logic [23:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [23:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0);
    q = rdata;
  endtask

  // ****************************************************************
  // Per-processor service
  // ****************************************************************
  function automatic logic [23:0] cpu_ofs(input logic [23:0] b, input logic c);
    return b + {11'h0, c, 12'h0};
  endfunction

  task automatic ack(input logic c, output logic [31:0] q);
    rd(cpu_ofs(`MPIS_ACK_OFS, c), q);
  endtask

  task automatic end_of_interrupt(input logic c);
    wr(cpu_ofs(`MPIS_EOI_OFS, c), 32'h0);
  endtask

  task automatic setctp(input logic c, input logic [31:0] v);
    wr(cpu_ofs(`MPIS_CTP_OFS, c), v);
  endtask
endmodule // mpis_host_model
`default_nettype wire

/* dv/multiprocessor_interrupt_service_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mpis_regs.svh"

module multiprocessor_interrupt_service_tb
  import mpis_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic [23:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] ext_irq;
  logic [1:0]  cpu_int;
  logic [1:0]  cpu_init;
  logic [31:0] q;
  int          fail_count;
  int          checks;
  localparam logic [3:0] PRIO [4] = '{4'h5, 4'h8, 4'h3, 4'h6};

  mpis_top #(.SCAN_DIV(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq(ext_irq),
    .cpu_int(cpu_int), .cpu_init(cpu_init)
  );

  mpis_host_model i_host (
    .pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wait_int(input int c, input logic v);
    int n;
    n = 0;
    while (cpu_int[c] !== v && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    chk("cpu_int", {31'h0, v}, {31'h0, cpu_int[c]});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic rdchk(input string nm, input logic [23:0] a, input logic [31:0] e);
    i_host.rd(a, q);
    chk(nm, e, q);
  endtask

  task automatic ackchk(input logic c, input logic [31:0] e);
    i_host.ack(c, q);
    chk("ack vector", e, q);
  endtask

  function automatic logic [23:0] at(input logic [23:0] b, input int n, input int s);
    return b + 24'(n * s);
  endfunction

  function automatic logic [31:0] vp(input logic m, input logic pol, input logic sns,
                                     input logic [3:0] p, input logic [7:0] v);
    return {m, 7'h0, pol, sns, 2'h0, p, 8'h0, v};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Whole sequence needs well under two thousand cycles; far above that means a hang
  initial
  begin
    #(100 * 20000);
    fail_count++;
    report_and_stop();
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    presetn = 1'b0;
    ext_irq = 16'h0;
    fail_count = 0;
    checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctp0", i_host.cpu_ofs(`MPIS_CTP_OFS, 1'b0), 32'hf);
    rdchk("ctp1", i_host.cpu_ofs(`MPIS_CTP_OFS, 1'b1), 32'hf);
    rdchk("src vp", `MPIS_EXTVP_OFS, 32'h80000000);
    rdchk("init", `MPIS_PINIT_OFS, 32'h0);
    i_host.rd(`MPIS_TBASE_OFS, q);
    chk("timer stop", 32'h1, {31'h0, q[31]});
    rdchk("mode", `MPIS_GCFG_OFS, 32'h0);
    chk("cpu_init", 32'h0, {30'h0, cpu_init});
    i_host.wr(`MPIS_PINIT_OFS, 32'h2);
    idle(1);
    chk("cpu_init", 32'h2, {30'h0, cpu_init});
    ackchk(1'b0, 32'hff);
    ext_irq[0] <= 1'b1;
    wait_int(0, 1'b1);
    ext_irq[0] <= 1'b0;
    wait_int(0, 1'b0);
    i_host.rd(24'h300000, q);
    chk("slverr", 32'h1, {31'h0, i_host.rerr});
    i_host.wr(`MPIS_GCFG_OFS, 32'h1);
    for (int n = 0; n < 4; n++)
      i_host.wr(at(`MPIS_IPIVP_OFS, n, 16), vp(0, 0, 0, PRIO[n], 8'(64 + n)));
    // Task priority gate, strictly above
    i_host.wr(`MPIS_DISP_OFS, 32'h1);
    idle(20);
    chk("blocked", 32'h0, {31'h0, cpu_int[0]});
    ackchk(1'b0, 32'hff);
    i_host.setctp(1'b0, 32'h5);
    idle(20);
    chk("equal prio", 32'h0, {31'h0, cpu_int[0]});
    i_host.setctp(1'b0, 32'h4);
    wait_int(0, 1'b1);
    ackchk(1'b0, 32'h40);
    wait_int(0, 1'b0);
    // Nesting: lower held off, higher let through, eoi retires the top one
    i_host.wr(at(`MPIS_DISP_OFS, 2, 16), 32'h1);
    idle(20);
    chk("lower held", 32'h0, {31'h0, cpu_int[0]});
    i_host.wr(at(`MPIS_DISP_OFS, 1, 16), 32'h1);
    wait_int(0, 1'b1);
    ackchk(1'b0, 32'h41);
    i_host.end_of_interrupt(1'b0);
    i_host.wr(at(`MPIS_DISP_OFS, 3, 16), 32'h1);
    wait_int(0, 1'b1);
    ackchk(1'b0, 32'h43);
    i_host.end_of_interrupt(1'b0);
    i_host.end_of_interrupt(1'b0);
    i_host.setctp(1'b0, 32'h0);
    wait_int(0, 1'b1);
    ackchk(1'b0, 32'h42);
    i_host.end_of_interrupt(1'b0);
    // Second processor, alias address, multicast to both
    i_host.setctp(1'b1, 32'h0);
    i_host.wr(at(`MPIS_DISP_OFS, 1, 16) + 24'h1000, 32'h2);
    wait_int(1, 1'b1);
    chk("other cpu", 32'h0, {31'h0, cpu_int[0]});
    ackchk(1'b1, 32'h41);
    i_host.end_of_interrupt(1'b1);
    i_host.wr(`MPIS_DISP_OFS, 32'h3);
    wait_int(0, 1'b1);
    wait_int(1, 1'b1);
    ackchk(1'b0, 32'h40);
    ackchk(1'b1, 32'h40);
    i_host.end_of_interrupt(1'b0);
    i_host.end_of_interrupt(1'b1);
    // Edge source seen while masked
    i_host.wr(at(`MPIS_EXTVP_OFS, 1, 32), vp(1, 1, 0, 4'h4, 8'h21));
    ext_irq[1] <= 1'b1;
    idle(50);
    chk("masked", 32'h0, {31'h0, cpu_int[0]});
    i_host.wr(at(`MPIS_EXTVP_OFS, 1, 32), vp(0, 1, 0, 4'h4, 8'h21));
    wait_int(0, 1'b1);
    ackchk(1'b0, 32'h21);
    wait_int(0, 1'b0);
    i_host.end_of_interrupt(1'b0);
    // Distributed: both destinations, lower task priority wins
    i_host.setctp(1'b0, 32'h5);
    i_host.setctp(1'b1, 32'h2);
    i_host.wr(at(`MPIS_EXTVP_OFS, 3, 32) + 24'h10, 32'h3);
    i_host.wr(at(`MPIS_EXTVP_OFS, 3, 32), vp(0, 1, 0, 4'h7, 8'h23));
    ext_irq[3] <= 1'b1;
    wait_int(1, 1'b1);
    chk("not cpu0", 32'h0, {31'h0, cpu_int[0]});
    ackchk(1'b1, 32'h23);
    i_host.end_of_interrupt(1'b1);
    // Level source negated long enough before its eoi
    i_host.setctp(1'b0, 32'h0);
    i_host.wr(at(`MPIS_EXTVP_OFS, 2, 32), vp(0, 1, 1, 4'h6, 8'h22));
    ext_irq[2] <= 1'b1;
    wait_int(0, 1'b1);
    ackchk(1'b0, 32'h22);
    ext_irq[2] <= 1'b0;
    idle(50);
    i_host.end_of_interrupt(1'b0);
    idle(20);
    chk("no spurious", 32'h0, {31'h0, cpu_int[0]});
    ackchk(1'b0, 32'hff);
    rdchk("activity", at(`MPIS_EXTVP_OFS, 2, 32), vp(0, 1, 1, 4'h6, 8'h22));
    // Timer source: released, fires, stopped before it can reload again
    i_host.wr(`MPIS_TVP_OFS, vp(0, 0, 0, 4'h9, 8'h50));
    i_host.wr(`MPIS_TBASE_OFS, 32'h14);
    wait_int(0, 1'b1);
    i_host.wr(`MPIS_TBASE_OFS, 32'h80000000);
    ackchk(1'b0, 32'h50);
    wait_int(0, 1'b0);
    i_host.end_of_interrupt(1'b0);
    // Every remaining external input, one edge each
    for (int s = 4; s < 16; s++)
    begin
      i_host.wr(at(`MPIS_EXTVP_OFS, s, 32), vp(0, 1, 0, 4'h9, 8'(48 + s)));
      ext_irq[s] <= 1'b1;
      wait_int(0, 1'b1);
      ackchk(1'b0, 32'(48 + s));
      i_host.end_of_interrupt(1'b0);
    end
    report_and_stop();
  end
endmodule // multiprocessor_interrupt_service_tb
`default_nettype wire
